// >>> src/dmm_pkg.sv
/*
 * Shared constants and types for the data memory mapper: special register
 * addresses, field positions, reset values, address map limits, access kinds
 * and the request and external-bus carriers.
 * Assumes the core presents one access at a time on the core clock.
 */
package dmm_pkg;

	// special register addresses decoded by the mapper
	localparam logic [7:0] SFR_DATA_POINTER_LOW  = 8'h82;
	localparam logic [7:0] SFR_DATA_POINTER_HIGH = 8'h83;
	localparam logic [7:0] SFR_PAGE_SEL  = 8'h85;
	localparam logic [7:0] SFR_WIN_BANK  = 8'h86;
	localparam logic [7:0] SFR_SYS_CONF  = 8'hBF;

	// field positions
	localparam int OME_BIT     = 1;
	localparam int WIN_EN_BIT  = 7;
	localparam int WIN_SEL_MSB = 3;
	localparam int PAGE_MSB    = 1;

	// reset values
	localparam logic [15:0] DATA_POINTER_RST    = 16'h0000;
	localparam logic [1:0]  PAGE_RST    = 2'h0;
	localparam logic        WIN_EN_RST  = 1'b0;
	localparam logic [3:0]  WIN_SEL_RST = 4'h0;
	localparam logic        OME_RST     = 1'b1;

	// address map
	localparam logic [7:0]  BIT_AREA_BASE = 8'h20;
	localparam logic [15:0] EXP_LAST      = 16'h02FF;
	localparam logic [9:0]  EXP_BASE      = 10'h100;
	localparam logic [1:0]  PAGE_EXTERNAL = 2'h3;
	localparam logic [15:0] DATA_POINTER_STEP     = 16'h0001;

	localparam int RAM_AW = 10;
	localparam int RAM_DW = 8;

	typedef enum logic [2:0] {
		KIND_DIRECT   = 3'h0,
		KIND_INDIRECT = 3'h1,
		KIND_REG      = 3'h2,
		KIND_BIT      = 3'h3,
		KIND_MOVX_DP  = 3'h4,
		KIND_MOVX_RN  = 3'h5
	} dmm_kind_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_READ = 3'b010,
		ST_EXT  = 3'b100
	} dmm_state_t;

	// one data memory access from the core
	typedef struct packed {
		dmm_kind_t   kind;
		logic        wr;
		logic [7:0]  addr;
		logic [7:0]  wdata;
	} dmm_req_t;

	// one cycle on the external memory bus
	typedef struct packed {
		logic [15:0] addr;
		logic        wr;
		logic [7:0]  wdata;
	} dmm_ext_t;

endpackage

// >>> src/dmm_ram.sv
/*
 * 1K byte on-chip data RAM, one port, synchronous read.
 * Assumes the mapper supplies a physical address: internal bytes at 000h-0FFh,
 * expanded bytes at 100h-3FFh.
 */
`timescale 1ns/1ns
`default_nettype none

module dmm_ram (
	input  wire logic                        core_clk,
	input  wire logic                        ce,
	input  wire logic                        we,
	input  wire logic [dmm_pkg::RAM_AW-1:0]  addr,
	input  wire logic [dmm_pkg::RAM_DW-1:0]  wdata,
	output logic      [dmm_pkg::RAM_DW-1:0]  rdata
);

	logic [dmm_pkg::RAM_DW-1:0] mem [0:(1 << dmm_pkg::RAM_AW)-1];

	// contents are not reset: RAM holds garbage at power up like the real array
	always_ff @(posedge core_clk) begin
		if (ce) begin
			if (we) begin
				mem[addr] <= wdata;
			end
			rdata <= mem[addr];
		end
	end

endmodule

`default_nettype wire

// >>> src/dmm_mapper.sv
/*
 * Data memory mapper: data pointer, page select, direct window and expanded
 * RAM enable registers, plus routing of every core data access outside special register space to the 1K
 * on-chip RAM or to the external memory bus.
 * Assumes the core, the status word and the external bus logic share core_clk;
 * the core waits for ack_r before issuing the next access.
 */
`timescale 1ns/1ns
`default_nettype none

module dmm_mapper (
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	input  wire logic              ce,
	input  wire logic              sfr_wr,
	input  wire logic              sfr_rd,
	input  wire logic [7:0]        sfr_addr,
	input  wire logic [7:0]        sfr_wdata,
	output logic      [7:0]        sfr_rdata_r,
	output logic                   sfr_hit_r,
	input  wire logic              data_pointer_inc,
	output logic      [15:0]       data_pointer_r,
	output logic                   expanded_ram_enable_r,
	input  wire logic              register_bank_select_high,
	input  wire logic              register_bank_select_low,
	input  wire logic [7:0]        port_two_latch,
	input  wire logic              mem_req,
	input  wire dmm_pkg::dmm_req_t mem_cmd,
	output logic                   mem_busy_r,
	output logic                   ack_r,
	output logic      [7:0]        rdata_r,
	output logic                   ext_req_r,
	output dmm_pkg::dmm_ext_t      ext_cmd_r,
	input  wire logic              ext_ack,
	input  wire logic [7:0]        ext_rdata
);

	logic [1:0]  page_r;
	logic [1:0]  page_nxt;
	logic        win_en_r;
	logic        win_en_nxt;
	logic [3:0]  win_sel_r;
	logic [3:0]  win_sel_nxt;
	logic [15:0] data_pointer_nxt;
	logic        ome_nxt;
	logic [7:0]  sfr_rdata_nxt;
	logic        sfr_hit_nxt;

	dmm_pkg::dmm_state_t state_r;
	dmm_pkg::dmm_state_t state_nxt;
	logic        ack_nxt;
	logic [7:0]  rdata_nxt;
	logic        ext_req_nxt;
	dmm_pkg::dmm_ext_t ext_cmd_nxt;
	logic [9:0]  hold_addr_r;
	logic [9:0]  hold_addr_nxt;
	logic        hold_bitop_r;
	logic        hold_bitop_nxt;
	logic        hold_wr_r;
	logic        hold_wr_nxt;
	logic [2:0]  hold_bit_r;
	logic [2:0]  hold_bit_nxt;
	logic        hold_wbit_r;
	logic        hold_wbit_nxt;

	logic [1:0]  bank_sel;
	logic        take;
	logic        refuse;
	logic        to_ext;
	logic [9:0]  phys;
	logic [15:0] ext_addr;
	logic [9:0]  ram_addr;
	logic        ram_we;
	logic [7:0]  ram_wdata;
	logic [7:0]  ram_q;

	assign bank_sel = {register_bank_select_high, register_bank_select_low};
	assign take     = ce && mem_req && (state_r == dmm_pkg::ST_IDLE);

	// special register writes and reads
	always_comb begin
		data_pointer_nxt      = data_pointer_r;
		page_nxt      = page_r;
		win_en_nxt    = win_en_r;
		win_sel_nxt   = win_sel_r;
		ome_nxt       = expanded_ram_enable_r;
		sfr_rdata_nxt = sfr_rdata_r;
		sfr_hit_nxt   = sfr_hit_r;
		if (ce) begin
			// an explicit byte write overrides the increment on that byte
			if (data_pointer_inc) begin
				data_pointer_nxt = data_pointer_r + dmm_pkg::DATA_POINTER_STEP;
			end
			if (sfr_wr) begin
				unique case (sfr_addr)
					dmm_pkg::SFR_DATA_POINTER_LOW:  data_pointer_nxt[7:0] = sfr_wdata;
					dmm_pkg::SFR_DATA_POINTER_HIGH: data_pointer_nxt[15:8] = sfr_wdata;
					dmm_pkg::SFR_PAGE_SEL:  page_nxt = sfr_wdata[dmm_pkg::PAGE_MSB:0];
					dmm_pkg::SFR_WIN_BANK: begin
						win_en_nxt  = sfr_wdata[dmm_pkg::WIN_EN_BIT];
						win_sel_nxt = sfr_wdata[dmm_pkg::WIN_SEL_MSB:0];
					end
					dmm_pkg::SFR_SYS_CONF:  ome_nxt = sfr_wdata[dmm_pkg::OME_BIT];
					default: ;
				endcase
			end
			if (sfr_rd) begin
				sfr_rdata_nxt = 8'h00;
				sfr_hit_nxt   = 1'b1;
				unique case (sfr_addr)
					dmm_pkg::SFR_DATA_POINTER_LOW:  sfr_rdata_nxt = data_pointer_r[7:0];
					dmm_pkg::SFR_DATA_POINTER_HIGH: sfr_rdata_nxt = data_pointer_r[15:8];
					dmm_pkg::SFR_PAGE_SEL:  sfr_rdata_nxt[dmm_pkg::PAGE_MSB:0] = page_r;
					dmm_pkg::SFR_WIN_BANK: begin
						sfr_rdata_nxt[dmm_pkg::WIN_EN_BIT]    = win_en_r;
						sfr_rdata_nxt[dmm_pkg::WIN_SEL_MSB:0] = win_sel_r;
					end
					dmm_pkg::SFR_SYS_CONF:
						sfr_rdata_nxt[dmm_pkg::OME_BIT] = expanded_ram_enable_r;
					default: sfr_hit_nxt = 1'b0;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			data_pointer_r        <= dmm_pkg::DATA_POINTER_RST;
			page_r                <= dmm_pkg::PAGE_RST;
			win_en_r              <= dmm_pkg::WIN_EN_RST;
			win_sel_r             <= dmm_pkg::WIN_SEL_RST;
			expanded_ram_enable_r <= dmm_pkg::OME_RST;
			sfr_rdata_r           <= 8'h00;
			sfr_hit_r             <= 1'b0;
		end else begin
			data_pointer_r        <= data_pointer_nxt;
			page_r                <= page_nxt;
			win_en_r              <= win_en_nxt;
			win_sel_r             <= win_sel_nxt;
			expanded_ram_enable_r <= ome_nxt;
			sfr_rdata_r           <= sfr_rdata_nxt;
			sfr_hit_r             <= sfr_hit_nxt;
		end
	end

	// address decode of the request in hand
	always_comb begin
		refuse   = 1'b0;
		to_ext   = 1'b0;
		phys     = {2'b00, mem_cmd.addr};
		ext_addr = {8'h00, mem_cmd.addr};
		unique case (mem_cmd.kind)
			dmm_pkg::KIND_DIRECT: begin
				// direct above 7Fh is special register space
				if (mem_cmd.addr[7]) begin
					refuse = 1'b1;
				// window slice at 40h-7Fh, slices 4-15 land in expanded
				end else if (win_en_r && mem_cmd.addr[6]) begin
					phys = {win_sel_r, mem_cmd.addr[5:0]};
				end
				// window off falls through to lower RAM
			end
			// indirect reaches all 256 internal bytes
			dmm_pkg::KIND_INDIRECT: phys = {2'b00, mem_cmd.addr};
			dmm_pkg::KIND_REG:      phys = {5'b00000, bank_sel, mem_cmd.addr[2:0]};
			dmm_pkg::KIND_BIT: begin
				if (mem_cmd.addr[7]) begin
					refuse = 1'b1;
				end else begin
					phys = {2'b00, dmm_pkg::BIT_AREA_BASE[7:4], mem_cmd.addr[6:3]};
				end
			end
			dmm_pkg::KIND_MOVX_DP: begin
				ext_addr = data_pointer_r;
				if (expanded_ram_enable_r && data_pointer_r <= dmm_pkg::EXP_LAST) begin
					phys = dmm_pkg::EXP_BASE + data_pointer_r[9:0];
				end else begin
					to_ext = 1'b1;
				end
			end
			dmm_pkg::KIND_MOVX_RN: begin
				// page 11 uses the port two latch
				if (page_r == dmm_pkg::PAGE_EXTERNAL) begin
					to_ext   = 1'b1;
					ext_addr = {port_two_latch, mem_cmd.addr};
				end else if (expanded_ram_enable_r) begin
					phys = dmm_pkg::EXP_BASE + {page_r, mem_cmd.addr};
				end else begin
					to_ext   = 1'b1;
					ext_addr = {6'h00, page_r, mem_cmd.addr};
				end
			end
			default: refuse = 1'b1;
		endcase
	end

	// access sequencer
	always_comb begin
		logic [7:0] merged;
		merged         = ram_q;
		state_nxt      = state_r;
		ack_nxt        = 1'b0;
		rdata_nxt      = rdata_r;
		ext_req_nxt    = ext_req_r;
		ext_cmd_nxt    = ext_cmd_r;
		hold_addr_nxt  = hold_addr_r;
		hold_bitop_nxt = hold_bitop_r;
		hold_wr_nxt    = hold_wr_r;
		hold_bit_nxt   = hold_bit_r;
		hold_wbit_nxt  = hold_wbit_r;
		ram_we         = 1'b0;
		ram_wdata      = mem_cmd.wdata;
		// the array must keep seeing the held address while frozen
		ram_addr       = (state_r == dmm_pkg::ST_IDLE) ? phys : hold_addr_r;
		if (ce) begin
			unique case (state_r)
				dmm_pkg::ST_IDLE: begin
					if (mem_req) begin
						hold_addr_nxt  = phys;
						hold_bitop_nxt = (mem_cmd.kind == dmm_pkg::KIND_BIT);
						hold_wr_nxt    = mem_cmd.wr;
						hold_bit_nxt   = mem_cmd.addr[2:0];
						hold_wbit_nxt  = mem_cmd.wdata[0];
						if (refuse) begin
							ack_nxt   = 1'b1;
							rdata_nxt = 8'h00;
						end else if (to_ext) begin
							ext_req_nxt = 1'b1;
							ext_cmd_nxt = '{addr: ext_addr, wr: mem_cmd.wr,
								wdata: mem_cmd.wdata};
							state_nxt   = dmm_pkg::ST_EXT;
						end else if (mem_cmd.wr && mem_cmd.kind != dmm_pkg::KIND_BIT) begin
							ram_we    = 1'b1;
							ack_nxt   = 1'b1;
							rdata_nxt = 8'h00;
						end else begin
							state_nxt = dmm_pkg::ST_READ;
						end
					end
				end
				dmm_pkg::ST_READ: begin
					ack_nxt   = 1'b1;
					state_nxt = dmm_pkg::ST_IDLE;
					rdata_nxt = ram_q;
					if (hold_bitop_r) begin
						merged[hold_bit_r] = hold_wbit_r;
						rdata_nxt = {7'h00, ram_q[hold_bit_r]};
						if (hold_wr_r) begin
							ram_we    = 1'b1;
							ram_wdata = merged;
							rdata_nxt = 8'h00;
						end
					end
				end
				dmm_pkg::ST_EXT: begin
					// no time-out: the external bus logic must answer
					if (ext_ack) begin
						ext_req_nxt = 1'b0;
						ack_nxt     = 1'b1;
						rdata_nxt   = ext_cmd_r.wr ? 8'h00 : ext_rdata;
						state_nxt   = dmm_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r      <= dmm_pkg::ST_IDLE;
			mem_busy_r   <= 1'b0;
			ack_r        <= 1'b0;
			rdata_r      <= 8'h00;
			ext_req_r    <= 1'b0;
			ext_cmd_r    <= '0;
			hold_addr_r  <= '0;
			hold_bitop_r <= 1'b0;
			hold_wr_r    <= 1'b0;
			hold_bit_r   <= 3'h0;
			hold_wbit_r  <= 1'b0;
		end else begin
			state_r      <= state_nxt;
			mem_busy_r   <= (state_nxt != dmm_pkg::ST_IDLE);
			ack_r        <= ce ? ack_nxt : ack_r;
			rdata_r      <= rdata_nxt;
			ext_req_r    <= ext_req_nxt;
			ext_cmd_r    <= ext_cmd_nxt;
			hold_addr_r  <= hold_addr_nxt;
			hold_bitop_r <= hold_bitop_nxt;
			hold_wr_r    <= hold_wr_nxt;
			hold_bit_r   <= hold_bit_nxt;
			hold_wbit_r  <= hold_wbit_nxt;
		end
	end

	dmm_ram u_ram (
		.core_clk (core_clk),
		.ce       (ce),
		.we       (ram_we),
		.addr     (ram_addr),
		.wdata    (ram_wdata),
		.rdata    (ram_q)
	);

	property p_data_pointer_low;
		@(posedge core_clk) disable iff (!rst_n)
		(ce && sfr_wr && sfr_addr == dmm_pkg::SFR_DATA_POINTER_LOW)
			|=> (data_pointer_r[7:0] == $past(sfr_wdata));
	endproperty
	a_data_pointer_low: assert property (p_data_pointer_low) else $error("pointer low byte not written");

	property p_ome_clear;
		@(posedge core_clk) disable iff (!rst_n)
		(ce && sfr_wr && sfr_addr == dmm_pkg::SFR_SYS_CONF && !sfr_wdata[dmm_pkg::OME_BIT])
			|=> !expanded_ram_enable_r;
	endproperty
	a_ome_clear: assert property (p_ome_clear) else $error("expanded RAM not disabled");

	property p_data_pointer_ext;
		@(posedge core_clk) disable iff (!rst_n)
		(take && mem_cmd.kind == dmm_pkg::KIND_MOVX_DP && data_pointer_r > dmm_pkg::EXP_LAST)
			|=> (ext_req_r && ext_cmd_r.addr == $past(data_pointer_r));
	endproperty
	a_data_pointer_ext: assert property (p_data_pointer_ext) else $error("high pointer move not external");

	property p_page_ext;
		@(posedge core_clk) disable iff (!rst_n)
		(take && mem_cmd.kind == dmm_pkg::KIND_MOVX_RN && page_r == dmm_pkg::PAGE_EXTERNAL)
			|=> (ext_req_r && ext_cmd_r.addr == {$past(port_two_latch), $past(mem_cmd.addr)});
	endproperty
	a_page_ext: assert property (p_page_ext) else $error("page 11 external address wrong");

	property p_page_map;
		@(posedge core_clk) disable iff (!rst_n)
		(take && mem_cmd.kind == dmm_pkg::KIND_MOVX_RN && page_r != dmm_pkg::PAGE_EXTERNAL
			&& expanded_ram_enable_r)
			|-> (ram_addr == dmm_pkg::EXP_BASE + {page_r, mem_cmd.addr}) ##1 !ext_req_r;
	endproperty
	a_page_map: assert property (p_page_map) else $error("paged move mapped wrong");

	property p_window;
		@(posedge core_clk) disable iff (!rst_n)
		(take && mem_cmd.kind == dmm_pkg::KIND_DIRECT && !mem_cmd.addr[7] && mem_cmd.addr[6])
			|-> (ram_addr == (win_en_r ? {win_sel_r, mem_cmd.addr[5:0]}
				: {2'b00, mem_cmd.addr}));
	endproperty
	a_window: assert property (p_window) else $error("direct window address wrong");

	property p_reg_bank;
		@(posedge core_clk) disable iff (!rst_n)
		(take && mem_cmd.kind == dmm_pkg::KIND_REG)
			|-> (ram_addr[9:5] == 5'h00 && ram_addr[4:3] == bank_sel);
	endproperty
	a_reg_bank: assert property (p_reg_bank) else $error("working register bank wrong");

	property p_ome_off;
		@(posedge core_clk) disable iff (!rst_n)
		(take && mem_cmd.kind == dmm_pkg::KIND_MOVX_DP && !expanded_ram_enable_r)
			|=> (ext_req_r && state_r == dmm_pkg::ST_EXT);
	endproperty
	a_ome_off: assert property (p_ome_off) else $error("disabled RAM move not external");

	property p_read_ack;
		@(posedge core_clk) disable iff (!rst_n)
		(take && !mem_cmd.wr && !refuse && !to_ext) ##1 ce |=> (ack_r && !mem_busy_r);
	endproperty
	a_read_ack: assert property (p_read_ack) else $error("on-chip read not answered");

endmodule

`default_nettype wire

// >>> tb/dmm_ext_mem.sv
/*
 * External memory bus partner: answers every external cycle of the mapper
 * after a programmable number of wait cycles and records what it saw.
 * Assumes one cycle at a time, request held until ext_ack, all on core_clk.
 */
`timescale 1ns/1ns
`default_nettype none

module dmm_ext_mem (
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	input  wire logic              ext_req_r,
	input  wire dmm_pkg::dmm_ext_t ext_cmd_r,
	input  wire logic [3:0]        wait_cycles,
	output logic                   ext_ack,
	output logic      [7:0]        ext_rdata,
	output dmm_pkg::dmm_ext_t      seen,
	output logic      [7:0]        n_ext
);
	logic [3:0] cnt;

	// read data is a fold of the address; between answers the bus toggles
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_ack <= 1'b0;
			ext_rdata <= 8'h00;
			cnt <= 4'h0;
			seen <= '0;
			n_ext <= 8'h00;
		end else if (ext_req_r && !ext_ack && cnt == wait_cycles) begin
			ext_ack <= 1'b1;
			ext_rdata <= ext_cmd_r.addr[7:0] ^ ext_cmd_r.addr[15:8] ^ 8'hA5;
			seen <= ext_cmd_r;
			n_ext <= n_ext + 8'h01;
			cnt <= 4'h0;
		end else begin
			ext_ack <= 1'b0;
			ext_rdata <= ~ext_rdata;
			cnt <= (ext_req_r && !ext_ack) ? cnt + 4'h1 : 4'h0;
		end
	end
endmodule

`default_nettype wire

// >>> tb/testbench.sv
/*
 * Self-checking bench for the data memory mapper: special register and
 * memory access tasks drive the core side, an external bus model answers.
 * Assumes inputs change at the falling edge and one access at a time.
 */
`timescale 1ns/1ns
`default_nettype none

module testbench;
	localparam dmm_pkg::dmm_kind_t DIR = dmm_pkg::KIND_DIRECT;
	localparam dmm_pkg::dmm_kind_t IND = dmm_pkg::KIND_INDIRECT;
	localparam dmm_pkg::dmm_kind_t DP  = dmm_pkg::KIND_MOVX_DP;
	localparam dmm_pkg::dmm_kind_t RN  = dmm_pkg::KIND_MOVX_RN;

	logic              core_clk, rst_n, ce, sfr_wr, sfr_rd, data_pointer_inc, mem_req;
	logic              register_bank_select_high, register_bank_select_low;
	logic              sfr_hit_r, expanded_ram_enable_r, mem_busy_r, ack_r;
	logic              ext_req_r, ext_ack;
	logic [7:0]        sfr_addr, sfr_wdata, sfr_rdata_r, port_two_latch, rdata_r;
	logic [7:0]        ext_rdata, n_ext, rd;
	logic [15:0]       data_pointer_r;
	logic [3:0]        wait_cycles;
	dmm_pkg::dmm_req_t mem_cmd;
	dmm_pkg::dmm_ext_t ext_cmd_r, seen;
	int                n_mismatch, checks_done;

	dmm_mapper dut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
		.sfr_rdata_r(sfr_rdata_r), .sfr_hit_r(sfr_hit_r), .data_pointer_inc(data_pointer_inc),
		.data_pointer_r(data_pointer_r), .expanded_ram_enable_r(expanded_ram_enable_r),
		.register_bank_select_high(register_bank_select_high),
		.register_bank_select_low(register_bank_select_low),
		.port_two_latch(port_two_latch), .mem_req(mem_req), .mem_cmd(mem_cmd),
		.mem_busy_r(mem_busy_r), .ack_r(ack_r), .rdata_r(rdata_r),
		.ext_req_r(ext_req_r), .ext_cmd_r(ext_cmd_r), .ext_ack(ext_ack),
		.ext_rdata(ext_rdata));

	dmm_ext_mem partner (.core_clk(core_clk), .rst_n(rst_n), .ext_req_r(ext_req_r),
		.ext_cmd_r(ext_cmd_r), .wait_cycles(wait_cycles), .ext_ack(ext_ack),
		.ext_rdata(ext_rdata), .seen(seen), .n_ext(n_ext));

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// an idle edge after each strobe keeps back-to-back calls legal
	task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge core_clk);
		sfr_wr = 1'b0;
		@(negedge core_clk);
	endtask

	task automatic sfr_r(input logic [7:0] a, input logic [7:0] exp, input logic hit);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge core_clk);
		sfr_rd = 1'b0;
		chk({8'h00, sfr_rdata_r}, {8'h00, exp});
		chk({15'h0, sfr_hit_r}, {15'h0, hit});
		@(negedge core_clk);
	endtask

	task automatic mem(input dmm_pkg::dmm_kind_t k, input logic w, input logic [7:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		mem_cmd.kind = k;
		mem_cmd.wr = w;
		mem_cmd.addr = a;
		mem_cmd.wdata = d;
		mem_req = 1'b1;
		@(negedge core_clk);
		mem_req = 1'b0;
		while (ack_r !== 1'b1 && n < 50) begin
			chk({15'h0, mem_busy_r}, 16'h0001);
			@(negedge core_clk);
			n++;
		end
		chk({15'h0, ack_r}, 16'h0001);
		chk({15'h0, mem_busy_r}, 16'h0000);
		rd = rdata_r;
		@(negedge core_clk);
	endtask

	task automatic data_pointer(input logic [15:0] v);
		sfr_w(dmm_pkg::SFR_DATA_POINTER_HIGH, v[15:8]);
		sfr_w(dmm_pkg::SFR_DATA_POINTER_LOW, v[7:0]);
	endtask

	function automatic logic [7:0] exf(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'hA5;
	endfunction

	initial begin
		#100000;
		n_mismatch++;
		results();
	end

	initial begin
		rst_n = 1'b0; ce = 1'b1; sfr_wr = 1'b0; sfr_rd = 1'b0; data_pointer_inc = 1'b0;
		mem_req = 1'b0; mem_cmd = '0; sfr_addr = 8'h00; sfr_wdata = 8'h00;
		register_bank_select_high = 1'b0; register_bank_select_low = 1'b0;
		port_two_latch = 8'h00; wait_cycles = 4'h0; n_mismatch = 0; checks_done = 0;
		repeat (5) @(negedge core_clk);
		rst_n = 1'b1;
		chk({15'h0, expanded_ram_enable_r}, 16'h0001);
		sfr_r(dmm_pkg::SFR_SYS_CONF, 8'h02, 1'b1);
		sfr_r(dmm_pkg::SFR_PAGE_SEL, 8'h00, 1'b1);
		sfr_r(dmm_pkg::SFR_WIN_BANK, 8'h00, 1'b1);
		sfr_r(8'h84, 8'h00, 1'b0);
		data_pointer(16'h12FF);
		chk(data_pointer_r, 16'h12FF);
		data_pointer_inc = 1'b1;
		@(negedge core_clk);
		data_pointer_inc = 1'b0;
		chk(data_pointer_r, 16'h1300);
		sfr_r(dmm_pkg::SFR_DATA_POINTER_HIGH, 8'h13, 1'b1);
		mem(DIR, 1'b1, 8'h70, 8'h77);
		mem(IND, 1'b0, 8'h70, 8'h00);
		chk({8'h00, rd}, 16'h0077);
		// a frozen clock enable stretches the read answer
		mem_cmd = '{IND, 1'b0, 8'h70, 8'h00};
		mem_req = 1'b1;
		@(negedge core_clk);
		mem_req = 1'b0;
		ce = 1'b0;
		repeat (3) @(negedge core_clk);
		chk({14'h0, ack_r, mem_busy_r}, 16'h0001);
		ce = 1'b1;
		@(negedge core_clk);
		chk({14'h0, ack_r, mem_busy_r}, 16'h0002);
		chk({8'h00, rdata_r}, 16'h0077);
		@(negedge core_clk);
		mem(DIR, 1'b1, 8'h45, 8'h4E);
		mem(IND, 1'b1, 8'h85, 8'hB5);
		mem(DIR, 1'b1, 8'h85, 8'hFF);
		mem(IND, 1'b0, 8'h85, 8'h00);
		chk({8'h00, rd}, 16'h00B5);
		mem(DIR, 1'b0, 8'h85, 8'h00);
		chk({8'h00, rd}, 16'h0000);
		for (int b = 0; b < 4; b++) begin
			{register_bank_select_high, register_bank_select_low} = 2'(b);
			mem(dmm_pkg::KIND_REG, 1'b1, 8'h03, 8'h10 + 8'(b));
		end
		for (int b = 0; b < 4; b++) begin
			mem(IND, 1'b0, 8'(b * 8 + 3), 8'h00);
			chk({8'h00, rd}, {8'h00, 8'h10 + 8'(b)});
		end
		mem(IND, 1'b1, 8'h21, 8'h00);
		mem(dmm_pkg::KIND_BIT, 1'b1, 8'h0A, 8'h01);
		mem(IND, 1'b0, 8'h21, 8'h00);
		chk({8'h00, rd}, 16'h0004);
		mem(dmm_pkg::KIND_BIT, 1'b0, 8'h0B, 8'h00);
		chk({8'h00, rd}, 16'h0000);
		mem(dmm_pkg::KIND_BIT, 1'b0, 8'h0A, 8'h00);
		chk({8'h00, rd}, 16'h0001);
		for (int p = 0; p < 3; p++) begin
			sfr_w(dmm_pkg::SFR_PAGE_SEL, 8'(p));
			sfr_r(dmm_pkg::SFR_PAGE_SEL, 8'(p), 1'b1);
			mem(RN, 1'b1, 8'h45, 8'h60 + 8'(p));
			data_pointer({6'h00, 2'(p), 8'h45});
			mem(DP, 1'b0, 8'h00, 8'h00);
			chk({8'h00, rd}, {8'h00, 8'h60 + 8'(p)});
			sfr_w(dmm_pkg::SFR_WIN_BANK, 8'h80 | 8'(p * 4 + 5));
			mem(DIR, 1'b0, 8'h45, 8'h00);
			chk({8'h00, rd}, {8'h00, 8'h60 + 8'(p)});
		end
		chk({8'h00, n_ext}, 16'h0000);
		sfr_w(dmm_pkg::SFR_WIN_BANK, 8'h82);
		mem(DIR, 1'b0, 8'h45, 8'h00);
		chk({8'h00, rd}, 16'h00B5);
		sfr_w(dmm_pkg::SFR_WIN_BANK, 8'h8C);
		mem(DIR, 1'b1, 8'h43, 8'h55);
		data_pointer(16'h0203);
		mem(DP, 1'b0, 8'h00, 8'h00);
		chk({8'h00, rd}, 16'h0055);
		sfr_w(dmm_pkg::SFR_WIN_BANK, 8'h0C);
		sfr_r(dmm_pkg::SFR_WIN_BANK, 8'h0C, 1'b1);
		mem(DIR, 1'b0, 8'h45, 8'h00);
		chk({8'h00, rd}, 16'h004E);
		data_pointer(16'h0300);
		mem(DP, 1'b1, 8'h00, 8'hC3);
		chk(seen.addr, 16'h0300);
		chk({7'h00, seen.wr, seen.wdata}, 16'h01C3);
		wait_cycles = 4'h5;
		data_pointer(16'h02FF);
		mem(DP, 1'b0, 8'h00, 8'h00);
		chk({8'h00, n_ext}, 16'h0001);
		sfr_w(dmm_pkg::SFR_PAGE_SEL, 8'h03);
		port_two_latch = 8'h9A;
		mem(RN, 1'b0, 8'h21, 8'h00);
		chk(seen.addr, 16'h9A21);
		chk({8'h00, rd}, {8'h00, exf(16'h9A21)});
		sfr_w(dmm_pkg::SFR_SYS_CONF, 8'h00);
		chk({15'h0, expanded_ram_enable_r}, 16'h0000);
		sfr_r(dmm_pkg::SFR_SYS_CONF, 8'h00, 1'b1);
		wait_cycles = 4'h0;
		data_pointer(16'h0145);
		mem(DP, 1'b0, 8'h00, 8'h00);
		chk(seen.addr, 16'h0145);
		chk({8'h00, rd}, {8'h00, exf(16'h0145)});
		sfr_w(dmm_pkg::SFR_PAGE_SEL, 8'h01);
		mem(RN, 1'b1, 8'h46, 8'h3C);
		chk(seen.addr, 16'h0146);
		sfr_w(dmm_pkg::SFR_SYS_CONF, 8'h02);
		mem(RN, 1'b0, 8'h45, 8'h00);
		chk({8'h00, rd}, 16'h0061);
		chk({8'h00, n_ext}, 16'h0004);
		rst_n = 1'b0;
		@(negedge core_clk);
		rst_n = 1'b1;
		chk(data_pointer_r, 16'h0000);
		sfr_r(dmm_pkg::SFR_PAGE_SEL, 8'h00, 1'b1);
		results();
	end
endmodule

`default_nettype wire
